// [cpudt_core.sv]
// Purpose: Fetch, operand gathering and execution for the decode tail core.
// Assumes: Memory answers a held read with mem_rvalid on the same clock.
// Notes:   Registers are reached over APB with one wait-free access cycle.
`timescale 1ns/100ps
`default_nettype none
module cpudt_core
  import cpudt_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_rd,
  output logic      [15:0] mem_addr,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_rvalid,
  input  wire logic        wake_irq,
  output logic             cpu_clk_en
);

  cpudt_state_t state_r, state_nxt;
  cpudt_dec_t   dec_r, dec_nxt, dec_w;
  logic [15:0]  pc_r, pc_nxt, opnd_r, opnd_nxt, ea_r, ea_nxt, addr_r, addr_nxt;
  logic [7:0]   acc_r, acc_nxt, x_r, x_nxt, data_r, data_nxt, opcode_r, opcode_nxt;
  logic [4:0]   ccr_r, ccr_nxt;
  logic [3:0]   clk_r, clk_nxt;
  logic [1:0]   cnt_r, cnt_nxt;
  logic [31:0]  cyc_r, cyc_nxt, prdata_r, prdata_nxt;
  logic         rd_r, rd_nxt, en_r, en_nxt, run_r, run_nxt, unsup_r, unsup_nxt;
  logic         pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic         done_w, take_w, wr_w, tst_ix_w, bit_w, taken_w;
  logic [7:0]   tst_val_w;

  cpudt_decode u_decode (
    .opcode (mem_rdata),
    .dec    (dec_w)
  );

  function automatic logic [15:0] ea_of(cpudt_mode_t m, logic [15:0] op, logic [7:0] x);
    case (m)
      full_address_mode:        ea_of = op;
      indexed_word_offset_mode: ea_of = op + {8'h00, x};
      indexed_byte_offset_mode: ea_of = {8'h00, op[7:0]} + {8'h00, x};
      indexed_plain_mode:       ea_of = {8'h00, x};
      bit_branch_mode:          ea_of = {8'h00, op[15:8]};
      default:                  ea_of = {8'h00, op[7:0]};
    endcase
  endfunction

  assign take_w   = rd_r && mem_rvalid;
  assign wr_w     = psel && penable && pready_r && pwrite;
  assign done_w   = (state_r == st_exec) && (({1'b0, clk_r} + 5'h01) >= {1'b0, dec_r.cycles});
  assign tst_ix_w = (state_r == st_idle);
  assign tst_val_w = (opcode_r == OP_TST_A) ? acc_r : (opcode_r == OP_TST_X) ? x_r : data_r;
  assign bit_w    = data_r[opcode_r[3:1]];
  assign taken_w  = opcode_r[0] ? !bit_w : bit_w;

  always_comb begin
    state_nxt  = state_r;
    dec_nxt    = dec_r;
    pc_nxt     = pc_r;
    opnd_nxt   = opnd_r;
    ea_nxt     = ea_r;
    addr_nxt   = addr_r;
    acc_nxt    = acc_r;
    x_nxt      = x_r;
    data_nxt   = data_r;
    opcode_nxt = opcode_r;
    ccr_nxt    = ccr_r;
    cnt_nxt    = cnt_r;
    cyc_nxt    = cyc_r;
    rd_nxt     = rd_r;
    unsup_nxt  = unsup_r;
    clk_nxt    = (clk_r == 4'hf) ? clk_r : clk_r + 4'h1;
    if (wr_w && paddr == OFS_STAT && pwdata[STAT_UNSUP]) begin
      unsup_nxt = 1'b0;
    end
    if (wr_w && tst_ix_w && paddr == OFS_PC) begin
      pc_nxt = pwdata[15:0];
    end
    if (wr_w && tst_ix_w && paddr == OFS_REGS) begin
      acc_nxt = pwdata[7:0];
      x_nxt   = pwdata[15:8];
      ccr_nxt = pwdata[20:16];
    end
    case (state_r)
      st_idle: begin
        clk_nxt = 4'h0;
        if (run_r) begin
          state_nxt = st_fetch;
          rd_nxt    = 1'b1;
          addr_nxt  = pc_r;
        end
      end
      st_fetch: begin
        if (take_w) begin
          opcode_nxt = mem_rdata;
          dec_nxt    = dec_w;
          pc_nxt     = pc_r + 16'h0001;
          opnd_nxt   = 16'h0000;
          cnt_nxt    = 2'd0;
          if (dec_w.nbytes != 2'd0) begin
            state_nxt = st_opnd;
            addr_nxt  = pc_r + 16'h0001;
          end else if (dec_w.needs_mem) begin
            state_nxt = st_data;
            addr_nxt  = ea_of(dec_w.mode, 16'h0000, x_r);
          end else begin
            state_nxt = st_exec;
            rd_nxt    = 1'b0;
          end
        end
      end
      st_opnd: begin
        if (take_w) begin
          opnd_nxt = {opnd_r[7:0], mem_rdata};
          pc_nxt   = pc_r + 16'h0001;
          cnt_nxt  = cnt_r + 2'd1;
          addr_nxt = pc_r + 16'h0001;
          if (cnt_r + 2'd1 == dec_r.nbytes) begin
            ea_nxt = ea_of(dec_r.mode, opnd_nxt, x_r);
            if (dec_r.needs_mem) begin
              state_nxt = st_data;
              addr_nxt  = ea_nxt;
            end else begin
              state_nxt = st_exec;
              rd_nxt    = 1'b0;
            end
          end
        end
      end
      st_data: begin
        if (take_w) begin
          data_nxt  = mem_rdata;
          ea_nxt    = addr_r;
          rd_nxt    = 1'b0;
          state_nxt = st_exec;
        end
      end
      st_exec: begin
        if (done_w) begin
          cyc_nxt = cyc_r + {28'h0000000, dec_r.cycles};
          clk_nxt = 4'h0;
          case (dec_r.cls)
            test_zero_negative_op: begin
              ccr_nxt[CCR_N] = tst_val_w[7];
              ccr_nxt[CCR_Z] = (tst_val_w == 8'h00);
            end
            index_to_acc_copy_op: acc_nxt = x_r;
            wait_op: ccr_nxt[CCR_I] = 1'b0;
            bit_branch_op: begin
              if (taken_w) begin
                pc_nxt = pc_r + {{8{opnd_r[7]}}, opnd_r[7:0]};
              end
            end
            default: unsup_nxt = 1'b1;
          endcase
          if (dec_r.cls == wait_op) begin
            state_nxt = st_sleep;
          end else if (run_r) begin
            state_nxt = st_fetch;
            rd_nxt    = 1'b1;
            addr_nxt  = pc_nxt;
          end else begin
            state_nxt = st_idle;
          end
        end
      end
      st_sleep: begin
        clk_nxt = 4'h0;
        if (wake_irq) begin
          state_nxt = run_r ? st_fetch : st_idle;
          rd_nxt    = run_r;
          addr_nxt  = pc_r;
        end
      end
      default: begin
        state_nxt = st_idle;
        rd_nxt    = 1'b0;
      end
    endcase
    en_nxt = (state_nxt != st_sleep);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r  <= st_idle;
      dec_r    <= '{mode: no_operand_mode, cls: cls_none, nbytes: 2'd0,
                    needs_mem: 1'b0, cycles: CYC_OTHER};
      pc_r     <= PC_RST;
      opnd_r   <= 16'h0000;
      ea_r     <= 16'h0000;
      addr_r   <= 16'h0000;
      acc_r    <= ACC_RST;
      x_r      <= X_RST;
      data_r   <= 8'h00;
      opcode_r <= 8'h00;
      ccr_r    <= CCR_RST;
      clk_r    <= 4'h0;
      cnt_r    <= 2'd0;
      cyc_r    <= 32'h00000000;
      rd_r     <= 1'b0;
      en_r     <= 1'b1;
      unsup_r  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      dec_r    <= dec_nxt;
      pc_r     <= pc_nxt;
      opnd_r   <= opnd_nxt;
      ea_r     <= ea_nxt;
      addr_r   <= addr_nxt;
      acc_r    <= acc_nxt;
      x_r      <= x_nxt;
      data_r   <= data_nxt;
      opcode_r <= opcode_nxt;
      ccr_r    <= ccr_nxt;
      clk_r    <= clk_nxt;
      cnt_r    <= cnt_nxt;
      cyc_r    <= cyc_nxt;
      rd_r     <= rd_nxt;
      en_r     <= en_nxt;
      unsup_r  <= unsup_nxt;
    end
  end

  // The APB slave answers in the first access cycle; read data is taken at setup.
  always_comb begin
    run_nxt     = run_r;
    pready_nxt  = psel && !penable;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    if (wr_w && paddr == OFS_CTRL) begin
      run_nxt = pwdata[CTRL_RUN];
    end
    if (psel && !penable) begin
      prdata_nxt = 32'h00000000;
      case (paddr)
        OFS_CTRL: prdata_nxt[CTRL_RUN] = run_r;
        OFS_PC:   prdata_nxt[15:0] = pc_r;
        OFS_REGS: prdata_nxt[20:0] = {ccr_r, x_r, acc_r};
        OFS_STAT: prdata_nxt[6:0] = {state_r, 1'b0, unsup_r, !en_r, run_r};
        OFS_EA:   prdata_nxt[15:0] = ea_r;
        OFS_CYC:  prdata_nxt = cyc_r;
        default:  pslverr_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      run_r     <= 1'b0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      run_r     <= run_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign mem_rd     = rd_r;
  assign mem_addr   = addr_r;
  assign cpu_clk_en = en_r;

  property p_tst_flags;
    @(posedge ref_clk) disable iff (reset)
    done_w && dec_r.cls == test_zero_negative_op |=>
      ccr_r[CCR_Z] == ($past(tst_val_w) == 8'h00) && ccr_r[CCR_N] == $past(tst_val_w[7])
      && ccr_r[4:3] == $past(ccr_r[4:3]) && ccr_r[CCR_C] == $past(ccr_r[CCR_C]);
  endproperty
  a_tst_flags: assert property (p_tst_flags) else $error("test flags wrong");

  property p_tst_cycles;
    @(posedge ref_clk) disable iff (reset)
    done_w && opcode_r == OP_TST_IX1 |-> clk_r >= 4'h4;
  endproperty
  a_tst_cycles: assert property (p_tst_cycles) else $error("test took too few cycles");

  property p_txa;
    @(posedge ref_clk) disable iff (reset)
    done_w && dec_r.cls == index_to_acc_copy_op |=> acc_r == $past(x_r) && ccr_r == $past(ccr_r);
  endproperty
  a_txa: assert property (p_txa) else $error("index copy wrong");

  property p_wait;
    @(posedge ref_clk) disable iff (reset)
    done_w && dec_r.cls == wait_op |=> state_r == st_sleep && !ccr_r[CCR_I] && !cpu_clk_en;
  endproperty
  a_wait: assert property (p_wait) else $error("wait did not halt");

  property p_word_order;
    @(posedge ref_clk) disable iff (reset)
    state_r == st_opnd && take_w && dec_r.nbytes == 2'd2 && cnt_r == 2'd1 |=>
      opnd_r[15:8] == $past(opnd_r[7:0]) && opnd_r[7:0] == $past(mem_rdata);
  endproperty
  a_word_order: assert property (p_word_order) else $error("operand byte order wrong");

  property p_byte_addr;
    @(posedge ref_clk) disable iff (reset)
    state_r == st_data && dec_r.mode == indexed_byte_offset_mode |->
      mem_addr == {8'h00, opnd_r[7:0]} + {8'h00, x_r};
  endproperty
  a_byte_addr: assert property (p_byte_addr) else $error("byte offset address wrong");

  property p_ext_addr;
    @(posedge ref_clk) disable iff (reset)
    state_r == st_data && dec_r.mode == full_address_mode |-> mem_addr == opnd_r;
  endproperty
  a_ext_addr: assert property (p_ext_addr) else $error("extended address wrong");

  property p_branch;
    @(posedge ref_clk) disable iff (reset)
    done_w && dec_r.cls == bit_branch_op |=>
      pc_r == $past(pc_r) + ($past(taken_w) ? {{8{$past(opnd_r[7])}}, $past(opnd_r[7:0])} : 16'h0000);
  endproperty
  a_branch: assert property (p_branch) else $error("bit branch target wrong");

  property p_opnd_len;
    @(posedge ref_clk) disable iff (reset)
    state_r == st_opnd |-> dec_r.nbytes == 2'd1 || dec_r.nbytes == 2'd2;
  endproperty
  a_opnd_len: assert property (p_opnd_len) else $error("operand length out of range");

  property p_ix_addr;
    @(posedge ref_clk) disable iff (reset)
    state_r == st_data && dec_r.mode == indexed_plain_mode |-> mem_addr == {8'h00, x_r};
  endproperty
  a_ix_addr: assert property (p_ix_addr) else $error("plain index address wrong");

  property p_mode_nibble;
    @(posedge ref_clk) disable iff (reset)
    state_r == st_exec && opcode_r[7:4] == 4'hd |-> dec_r.mode == indexed_word_offset_mode;
  endproperty
  a_mode_nibble: assert property (p_mode_nibble) else $error("mode decode wrong");

  c_wait_wake: cover property (@(posedge ref_clk) disable iff (reset)
    state_r == st_sleep ##1 state_r == st_fetch);
  c_branch_taken: cover property (@(posedge ref_clk) disable iff (reset)
    done_w && dec_r.cls == bit_branch_op && taken_w);
  c_tst_zero: cover property (@(posedge ref_clk) disable iff (reset)
    done_w && dec_r.cls == test_zero_negative_op && tst_val_w == 8'h00);
  c_word_mode: cover property (@(posedge ref_clk) disable iff (reset)
    done_w && dec_r.mode == indexed_word_offset_mode);

endmodule
`default_nettype wire

// [cpudt_decode.sv]
// Purpose: Combinational opcode decoder.
// Assumes: Opcode byte is stable while it is decoded.
// Notes:   Upper nibble picks the mode and the bit-branch operation, the whole opcode byte the other operations.
`timescale 1ns/100ps
`default_nettype none
module cpudt_decode
  import cpudt_pkg::*;
(
  input  wire logic [7:0] opcode,
  output cpudt_dec_t      dec
);

  always_comb begin
    dec = '{mode: no_operand_mode, cls: cls_none, nbytes: 2'd0,
            needs_mem: 1'b0, cycles: CYC_OTHER};
    case (opcode[7:4])
      4'h0: begin
        dec.mode      = bit_branch_mode;
        dec.nbytes    = 2'd2;
        dec.cls       = bit_branch_op;
        dec.needs_mem = 1'b1;
        dec.cycles    = CYC_BITBR;
      end
      4'h1: begin dec.mode = bit_direct_mode; dec.nbytes = 2'd1; end
      4'h2: begin dec.mode = relative_mode; dec.nbytes = 2'd1; end
      4'h3, 4'hb: begin dec.mode = direct_mode; dec.nbytes = 2'd1; end
      4'h6, 4'he: begin dec.mode = indexed_byte_offset_mode; dec.nbytes = 2'd1; end
      4'h7, 4'hf: begin dec.mode = indexed_plain_mode; end
      4'ha: begin dec.mode = immediate_mode; dec.nbytes = 2'd1; end
      4'hc: begin dec.mode = full_address_mode; dec.nbytes = 2'd2; end
      4'hd: begin dec.mode = indexed_word_offset_mode; dec.nbytes = 2'd2; end
      default: begin dec.mode = no_operand_mode; end
    endcase
    case (opcode)
      OP_TST_DIR: begin dec.cls = test_zero_negative_op; dec.needs_mem = 1'b1; dec.cycles = CYC_TST_DIR; end
      OP_TST_A:   begin dec.cls = test_zero_negative_op; dec.cycles = CYC_TST_INH; end
      OP_TST_X:   begin dec.cls = test_zero_negative_op; dec.cycles = CYC_TST_INH; end
      OP_TST_IX1: begin dec.cls = test_zero_negative_op; dec.needs_mem = 1'b1; dec.cycles = CYC_TST_IX1; end
      OP_TST_IX:  begin dec.cls = test_zero_negative_op; dec.needs_mem = 1'b1; dec.cycles = CYC_TST_IX; end
      OP_TXA:     begin dec.cls = index_to_acc_copy_op; dec.cycles = CYC_TXA; end
      OP_WAIT:    begin dec.cls = wait_op; dec.cycles = CYC_WAIT; end
      default:    begin end
    endcase
  end

endmodule
`default_nettype wire

// [cpudt_mem_model.sv]
// Purpose: Byte-wide program and data memory answering the core's reads.
// Assumes: One read at a time, held by the core until it is answered.
// Notes:   Answers after lat idle cycles; an idle data bus shows the inverted last byte.
`timescale 1ns/100ps
`default_nettype none
module cpudt_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  input  wire logic [1:0]  lat,
  output logic      [7:0]  mem_rdata,
  output logic             mem_rvalid
);
  logic [7:0] mem [0:65535];
  logic [1:0] waited_r;
  logic [7:0] last_r;

  // Answer only a request that is raised, so a stray valid never helps the core.
  assign mem_rvalid = mem_rd && (waited_r >= lat);
  assign mem_rdata  = mem_rvalid ? mem[mem_addr] : ~last_r;

  always_ff @(posedge ref_clk) begin
    if (reset || !mem_rd || mem_rvalid) begin
      waited_r <= 2'h0;
    end else begin
      waited_r <= waited_r + 2'h1;
    end
    if (reset) begin
      last_r <= 8'ha5;
    end else if (mem_rvalid) begin
      last_r <= mem[mem_addr];
    end
  end
endmodule
`default_nettype wire

// [cpudt_pkg.sv]
// Purpose: Shared constants and types for the opcode decode tail core.
// Assumes: APB register map with 32-bit words and one byte-wide memory port.
// Notes:   Cycle figures are whole instruction cycles at the core clock.
package cpudt_pkg;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PC   = 8'h04;
  localparam logic [7:0] OFS_REGS = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_EA   = 8'h10;
  localparam logic [7:0] OFS_CYC  = 8'h14;

  localparam int CTRL_RUN   = 0;
  localparam int STAT_RUN   = 0;
  localparam int STAT_SLEEP = 1;
  localparam int STAT_UNSUP = 2;
  localparam int STAT_STATE = 4;

  localparam int CCR_H = 4;
  localparam int CCR_I = 3;
  localparam int CCR_N = 2;
  localparam int CCR_Z = 1;
  localparam int CCR_C = 0;

  localparam logic [4:0]  CCR_RST = 5'h08;
  localparam logic [15:0] PC_RST  = 16'h0000;
  localparam logic [7:0]  ACC_RST = 8'h00;
  localparam logic [7:0]  X_RST   = 8'h00;

  localparam logic [7:0] OP_TST_DIR = 8'h3d;
  localparam logic [7:0] OP_TST_A   = 8'h4d;
  localparam logic [7:0] OP_TST_X   = 8'h5d;
  localparam logic [7:0] OP_TST_IX1 = 8'h6d;
  localparam logic [7:0] OP_TST_IX  = 8'h7d;
  localparam logic [7:0] OP_TXA     = 8'h9f;
  localparam logic [7:0] OP_WAIT    = 8'h8f;

  localparam logic [3:0] CYC_TST_DIR = 4'h4;
  localparam logic [3:0] CYC_TST_INH = 4'h3;
  localparam logic [3:0] CYC_TST_IX1 = 4'h5;
  localparam logic [3:0] CYC_TST_IX  = 4'h4;
  localparam logic [3:0] CYC_TXA     = 4'h2;
  localparam logic [3:0] CYC_WAIT    = 4'h2;
  localparam logic [3:0] CYC_BITBR   = 4'h5;
  localparam logic [3:0] CYC_OTHER   = 4'h2;

  typedef enum logic [2:0] {
    st_idle  = 3'b000,
    st_fetch = 3'b001,
    st_opnd  = 3'b011,
    st_data  = 3'b010,
    st_exec  = 3'b110,
    st_sleep = 3'b111
  } cpudt_state_t;

  typedef enum logic [3:0] {
    bit_branch_mode          = 4'h0,
    bit_direct_mode          = 4'h1,
    relative_mode            = 4'h2,
    direct_mode              = 4'h3,
    no_operand_mode          = 4'h4,
    indexed_byte_offset_mode = 4'h5,
    indexed_plain_mode       = 4'h6,
    immediate_mode           = 4'h7,
    full_address_mode        = 4'h8,
    indexed_word_offset_mode = 4'h9
  } cpudt_mode_t;

  typedef enum logic [2:0] {
    cls_none              = 3'h0,
    test_zero_negative_op = 3'h1,
    index_to_acc_copy_op  = 3'h2,
    wait_op               = 3'h3,
    bit_branch_op         = 3'h4
  } cpudt_cls_t;

  typedef struct packed {
    cpudt_mode_t mode;
    cpudt_cls_t  cls;
    logic [1:0]  nbytes;
    logic        needs_mem;
    logic [3:0]  cycles;
  } cpudt_dec_t;

endpackage

// [tb_top.sv]
// Purpose: Self-checking bench for the opcode decode tail core.
// Assumes: APB answers in one cycle; memory answers after zero to three wait cycles.
// Notes:   Drivers note expected results in queues; a monitor compares them.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import cpudt_pkg::*;
();
  logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic        mem_rd, mem_rvalid, wake_irq, cpu_clk_en;
  logic [7:0]  paddr, mem_rdata, x, a, lo, hi, d, op;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] mem_addr, ea;
  logic [4:0]  fl;
  logic [1:0]  lat;
  logic [32:0] m, exp_q[$], msk_q[$];
  logic [15:0] ma_q[$];
  int          gap_q[$], miscompares, n_compared, cyc, last_op, g, i;
  localparam logic [7:0] PROG [0:22] = '{8'h3d, 8'h40, 8'h6d, 8'h20, 8'h7d, 8'h4d, 8'h5d,
    8'h9f, 8'hd6, 8'h12, 8'h34, 8'h00, 8'h41, 8'h05, 8'h9d, 8'h9d, 8'h9d, 8'h9d, 8'h9d,
    8'h01, 8'h41, 8'h03, 8'h8f};
  localparam logic [15:0] RDS [0:22] = '{16'h100, 16'h101, 16'h40, 16'h102, 16'h103, 16'hb0,
    16'h104, 16'h90, 16'h105, 16'h106, 16'h107, 16'h108, 16'h109, 16'h10a, 16'h10b, 16'h10c,
    16'h10d, 16'h41, 16'h113, 16'h114, 16'h115, 16'h41, 16'h116};
  localparam int GAPS [0:22] = '{0, -1, -1, 4, -1, -1, 5, -1, 4, 3, 3, 2, -1, -1, 0, -1, -1,
    -1, 5, -1, -1, -1, 5};

  cpudt_core dut_u (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid), .wake_irq(wake_irq), .cpu_clk_en(cpu_clk_en));
  cpudt_mem_model mem_u (.ref_clk(ref_clk), .reset(reset), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .lat(lat), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));

  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;

  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic guard(input int k, input int lim);
    if (k >= lim) begin
      miscompares++;
      close_out();
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] v,
                     input logic [32:0] e, input logic [32:0] mk);
    int k;
    exp_q.push_back(e);
    msk_q.push_back(mk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= ad;
    pwdata <= v;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    @(negedge ref_clk);
    while (pready !== 1'b1 && k < 20) begin
      @(negedge ref_clk);
      k++;
    end
    guard(k, 20);
    rd = prdata;
    @(posedge ref_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    apb(1'b1, ad, v, 33'h0, {1'b1, 32'h0});
  endtask

  task automatic rdc(input logic [7:0] ad, input logic [31:0] v, input logic [31:0] mk);
    apb(1'b0, ad, 32'h0, {1'b0, v}, {1'b1, mk});
  endtask

  task automatic exp_rd(input logic [15:0] ad, input int gp);
    ma_q.push_back(ad);
    gap_q.push_back(gp);
  endtask

  task automatic wait_sleep();
    int k;
    k = 0;
    @(negedge ref_clk);
    while (cpu_clk_en !== 1'b0 && k < 400) begin
      @(negedge ref_clk);
      k++;
    end
    guard(k, 400);
    @(posedge ref_clk);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, OFS_STAT, 32'h0, 33'h0, 33'h0);
      k++;
    end while (rd[6:4] !== 3'b000 && k < 50);
    guard(k, 50);
  endtask

  task automatic wake();
    wake_irq <= 1'b1;
    @(posedge ref_clk);
    wake_irq <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check("clk_en", {32'h0, cpu_clk_en}, 33'h1);
    @(posedge ref_clk);
  endtask

  // Monitor: every finished bus transfer and memory read takes the oldest note.
  always @(posedge ref_clk) begin
    cyc++;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      m = msk_q.pop_front();
      check("apb", {pslverr, prdata} & m, exp_q.pop_front());
    end
    if (mem_rd === 1'b1 && mem_rvalid === 1'b1) begin
      g = gap_q.pop_front();
      check("mem_addr", {17'h0, mem_addr}, {17'h0, ma_q.pop_front()});
      if (g > 0) check("op_cycles", 33'(cyc - last_op), 33'(g));
      if (g >= 0) last_op = cyc;
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    close_out();
  end

  initial begin
    {psel, penable, pwrite, wake_irq, reset} = 5'h01;
    {paddr, pwdata, lat} = '0;
    {miscompares, n_compared, cyc, last_op} = '0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    void'($urandom(32'hcb37));
    rdc(OFS_CTRL, 32'h0, 32'hffffffff);
    rdc(OFS_PC, 32'h0, 32'hffffffff);
    rdc(OFS_REGS, 32'h00080000, 32'hffffffff);
    rdc(OFS_STAT, 32'h0, 32'hffffffff);
    apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0}, {33{1'b1}});
    for (i = 0; i < 23; i++) begin
      mem_u.mem[16'h100 + 16'(i)] = PROG[i];
      exp_rd(RDS[i], GAPS[i]);
    end
    {mem_u.mem[16'h40], mem_u.mem[16'hb0]} = 16'h007f;
    {mem_u.mem[16'h90], mem_u.mem[16'h41]} = 16'h0001;
    wr(OFS_PC, 32'h100);
    wr(OFS_REGS, 32'h00199055);
    rdc(OFS_REGS, 32'h00199055, 32'hffffffff);
    wr(OFS_CTRL, 32'h1);
    wait_sleep();
    rdc(OFS_STAT, 32'h77, 32'h77);
    rdc(OFS_REGS, 32'h00159090, 32'hffffffff);
    rdc(OFS_CYC, 32'h23, 32'hffffffff);
    rdc(OFS_EA, 32'h41, 32'hffff);
    wr(OFS_STAT, 32'h4);
    wr(OFS_PC, 32'h300);
    wr(OFS_CTRL, 32'h0);
    wake();
    wait_idle();
    rdc(OFS_STAT, 32'h0, 32'h77);
    rdc(OFS_PC, 32'h117, 32'hffff);
    for (i = 0; i < 6; i++) begin
      x = 8'($urandom);
      a = 8'($urandom);
      lo = 8'($urandom);
      hi = 8'($urandom);
      d = 8'($urandom);
      lat <= 2'($urandom);
      op = (i % 3 == 0) ? OP_TST_IX1 : ((i % 3 == 1) ? 8'hd6 : 8'hc6);
      ea = (op == 8'hc6) ? {hi, lo} : ((op == 8'hd6) ? {hi, lo} + 16'(x) : 16'(lo) + 16'(x));
      fl = (op == OP_TST_IX1) ? {2'b00, d[7], d == 8'h00, 1'b0} : 5'h00;
      mem_u.mem[16'h200] = op;
      mem_u.mem[16'h201] = (op == OP_TST_IX1) ? lo : hi;
      mem_u.mem[16'h202] = (op == OP_TST_IX1) ? 8'h8f : lo;
      mem_u.mem[16'h203] = 8'h8f;
      mem_u.mem[ea] = (op == OP_TST_IX1) ? d : mem_u.mem[ea];
      exp_rd(16'h200, 0);
      exp_rd(16'h201, -1);
      exp_rd((op == OP_TST_IX1) ? ea : 16'h202, -1);
      exp_rd((op == OP_TST_IX1) ? 16'h202 : 16'h203, 0);
      wr(OFS_PC, 32'h200);
      wr(OFS_REGS, {11'h0, 5'h08, x, a});
      wr(OFS_CTRL, 32'h1);
      wait_sleep();
      rdc(OFS_EA, 32'(ea), 32'hffff);
      rdc(OFS_REGS, {11'h0, fl, x, a}, 32'hffffffff);
      wr(OFS_CTRL, 32'h0);
      wake();
      wait_idle();
    end
    check("reads_left", 33'(ma_q.size()), 33'h0);
    close_out();
  end
endmodule
`default_nettype wire
